//--- verilog/sbc_device.sv
// Sensor end: decodes command frames and answers register reads.
`timescale 1ns/100ps
`include "sbc_consts.svh"

// Operation
// RULE1 - Code 0000 is a register pair read.
// RULE2 - Code 1000 writes: byte address, then value.
// RULE3 - Code 1011 enters periodic collection; data ignored.
// RULE4 - Other codes: no action, no response.
// RULE5 - Answer reads only on node match, good check.
// RULE6 - Other nodes, broadcast included, get silence.
// RULE7 - Read data: even address high, rest zero.
// RULE8 - Answer holds contents captured at decode.
// RULE9 - Unreadable register answers with zero data.
// RULE10 - Unmapped address answers with zero data.
// RULE11 - Answer echoes own node and code 0000.
// RULE12 - High byte odd address, low byte even.
// RULE13 - Frames end with an eight-bit check byte.
// RULE14 - Check: given polynomial, ones seed, MSB first.
// RULE15 - Whole frame through checker leaves zero.
module sbc_device #(
    parameter int REG_BYTES = 64,
    parameter logic [255:0] READ_MASK = {256{1'b1}}
) (
    input wire logic clk,
    input wire logic reset,
    sbc_link_if.dev link,
    input wire sbc_pkg::sbc_nibble_t nodeAddress,
    input wire logic localWrEn,
    input wire sbc_pkg::sbc_byte_t localWrAddr,
    input wire sbc_pkg::sbc_byte_t localWrData,
    output logic writeReqValid,
    output sbc_pkg::sbc_byte_t writeReqAddr,
    output sbc_pkg::sbc_byte_t writeReqData,
    output logic collectModeReq,
    output logic crcError,
    output logic cmdIgnored
);
    import sbc_pkg::*;

    // ----------------------------------------------------------------
    // Register bytes
    // ----------------------------------------------------------------
    sbc_byte_t regs_ff [REG_BYTES];
    sbc_byte_t nxt_regs [REG_BYTES];

    // Local logic owns the contents; the link only reads them here.
    for (genvar i = 0; i < REG_BYTES; i++) begin : g_reg
        always_comb begin
            nxt_regs[i] = regs_ff[i];
            if (localWrEn && (localWrAddr == 8'(i))) begin
                nxt_regs[i] = localWrData;
            end
        end

        // Bytes clear on reset. The link only reads them; a write command
        // is forwarded to the owner instead of landing here.
        always_ff @(posedge clk) begin
            if (reset) begin
                regs_ff[i] <= `SBC_BYTE_ZERO;
            end else begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    // Unmapped and unreadable bytes both read as zero.
    function automatic sbc_byte_t readByte(input sbc_byte_t idx);
        sbc_byte_t val;
        val = `SBC_BYTE_ZERO;
        for (int k = 0; k < REG_BYTES; k++) begin
            if ((idx == 8'(k)) && READ_MASK[k]) begin // RULE9 RULE10
                val = regs_ff[k];
            end
        end
        return val;
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Each registered output has its next value declared beside it.
    sbc_dev_state_e state_ff, nxt_state;
    sbc_frame_t cmd_ff, nxt_cmd;
    logic rspValid_ff, nxt_rspValid;
    sbc_frame_t rspFrame_ff, nxt_rspFrame;
    logic writeReqValid_ff, nxt_writeReqValid;
    sbc_byte_t writeReqAddr_ff, nxt_writeReqAddr;
    sbc_byte_t writeReqData_ff, nxt_writeReqData;
    logic collectModeReq_ff, nxt_collectModeReq;
    logic crcError_ff, nxt_crcError;
    logic cmdIgnored_ff, nxt_cmdIgnored;
    // Fields and answer bytes worked out from the latched frame.
    logic crcOk;
    logic nodeHit;
    sbc_nibble_t code;
    sbc_byte_t evenAddr;
    sbc_byte_t hiByte;
    sbc_byte_t loByte;
    logic [23:0] rspMsg;

    // The frame is latched first so the check and the byte capture
    // both see a stable copy; the answer leaves the cycle after.
    always_comb begin
        crcOk = (sbc_crc_run(cmd_ff) == `SBC_CRC_ZERO); // RULE13 RULE14 RULE15
        // Broadcast never matches, so a node set to zero still stays silent.
        nodeHit = (cmd_ff[`SBC_ADDR_HI:`SBC_ADDR_LO] == nodeAddress) && // RULE5
            (cmd_ff[`SBC_ADDR_HI:`SBC_ADDR_LO] != `SBC_GLOBAL_ADDR); // RULE6
        code = cmd_ff[`SBC_CMD_HI:`SBC_CMD_LO];
        evenAddr = {cmd_ff[`SBC_EVEN_HI:`SBC_EVEN_LO], 1'b0}; // RULE7
        hiByte = readByte(evenAddr | `SBC_HI_BYTE_OFS); // RULE12
        loByte = readByte(evenAddr); // RULE12
        rspMsg = {nodeAddress, `SBC_CMD_READ, hiByte, loByte}; // RULE11 RULE12
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Commands arriving in the decode cycle are dropped; the master spaces reads only, as it waits for their answer.
    // A bad check wins over every decode, so a damaged frame never acts.
    always_comb begin
        nxt_state = state_ff;
        nxt_cmd = cmd_ff;
        nxt_rspValid = 1'b0;
        nxt_rspFrame = rspFrame_ff;
        nxt_writeReqValid = 1'b0;
        nxt_writeReqAddr = writeReqAddr_ff;
        nxt_writeReqData = writeReqData_ff;
        nxt_collectModeReq = 1'b0;
        nxt_crcError = 1'b0;
        nxt_cmdIgnored = 1'b0;
        unique case (state_ff)
            SBC_DEV_IDLE: begin
                if (link.cmdValid) begin
                    nxt_cmd = link.cmdFrame;
                    nxt_state = SBC_DEV_DECODE;
                end
            end
            SBC_DEV_DECODE: begin
                nxt_state = SBC_DEV_IDLE;
                if (!crcOk) begin
                    nxt_crcError = 1'b1; // RULE5 RULE15
                end else if (code == `SBC_CMD_READ) begin // RULE1
                    if (nodeHit) begin
                        // Bytes are taken now; later changes do not reach the answer.
                        nxt_rspValid = 1'b1; // RULE5 RULE8
                        nxt_rspFrame = {rspMsg, sbc_crc_run({rspMsg, `SBC_CRC_ZERO})}; // RULE13
                    end else begin
                        nxt_cmdIgnored = 1'b1; // RULE6
                    end
                end else if (code == `SBC_CMD_WRITE) begin // RULE2
                    // Execution and its answer belong to the register owner.
                    nxt_writeReqValid = 1'b1;
                    nxt_writeReqAddr = cmd_ff[`SBC_BADDR_HI:`SBC_BADDR_LO];
                    nxt_writeReqData = cmd_ff[`SBC_WDATA_HI:`SBC_WDATA_LO];
                end else if (code == `SBC_CMD_PERIODIC_COLLECTION_MODE) begin // RULE3
                    nxt_collectModeReq = 1'b1;
                end else begin
                    nxt_cmdIgnored = 1'b1; // RULE4
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    // Only registering here; every decision sits in the process above.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= SBC_DEV_IDLE;
            cmd_ff <= `SBC_FRAME_ZERO;
            rspValid_ff <= 1'b0;
            rspFrame_ff <= `SBC_FRAME_ZERO;
            writeReqValid_ff <= 1'b0;
            writeReqAddr_ff <= `SBC_BYTE_ZERO;
            writeReqData_ff <= `SBC_BYTE_ZERO;
            collectModeReq_ff <= 1'b0;
            crcError_ff <= 1'b0;
            cmdIgnored_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            rspValid_ff <= nxt_rspValid;
            rspFrame_ff <= nxt_rspFrame;
            writeReqValid_ff <= nxt_writeReqValid;
            writeReqAddr_ff <= nxt_writeReqAddr;
            writeReqData_ff <= nxt_writeReqData;
            collectModeReq_ff <= nxt_collectModeReq;
            crcError_ff <= nxt_crcError;
            cmdIgnored_ff <= nxt_cmdIgnored;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output comes straight from a flip-flop, so the far end never
    // sees decode glitches.
    assign link.rspValid = rspValid_ff;
    assign link.rspFrame = rspFrame_ff;
    assign writeReqValid = writeReqValid_ff;
    assign writeReqAddr = writeReqAddr_ff;
    assign writeReqData = writeReqData_ff;
    assign collectModeReq = collectModeReq_ff;
    assign crcError = crcError_ff;
    assign cmdIgnored = cmdIgnored_ff;
endmodule

//--- verilog/sbc_consts.svh
// Constants shared by both ends of the sensor bus command link.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SBC_CMD_READ 4'h0
`define SBC_CMD_WRITE 4'h8
`define SBC_CMD_PERIODIC_COLLECTION_MODE 4'hb

// ----------------------------------------------------------------
// Frame field positions
// ----------------------------------------------------------------
`define SBC_ADDR_HI 31
`define SBC_ADDR_LO 28
`define SBC_CMD_HI 27
`define SBC_CMD_LO 24
`define SBC_DATA_HI 23
`define SBC_DATA_LO 8
`define SBC_CRC_HI 7
`define SBC_CRC_LO 0
`define SBC_EVEN_HI 23
`define SBC_EVEN_LO 17
`define SBC_BADDR_HI 23
`define SBC_BADDR_LO 16
`define SBC_WDATA_HI 15
`define SBC_WDATA_LO 8

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define SBC_GLOBAL_ADDR 4'h0
`define SBC_CRC_SEED 8'hff
`define SBC_CRC_POLY 8'h2f
`define SBC_CRC_ZERO 8'h00
`define SBC_BYTE_ZERO 8'h00
`define SBC_HI_BYTE_OFS 8'h01
`define SBC_READ_PAD 9'h000
`define SBC_FRAME_ZERO 32'h0000_0000
`define SBC_RSP_TIMEOUT 64

`endif

//--- verilog/sbc_pkg.sv
// Types and the frame check function of the sensor bus command link.
package sbc_pkg;
    `include "sbc_consts.svh"

    typedef logic [31:0] sbc_frame_t;
    typedef logic [3:0] sbc_nibble_t;
    typedef logic [7:0] sbc_byte_t;

    typedef enum logic [0:0] {SBC_DEV_IDLE, SBC_DEV_DECODE} sbc_dev_state_e;
    typedef enum logic [1:0] {SBC_MST_IDLE, SBC_MST_WAIT, SBC_MST_CHECK} sbc_mst_state_e;

    // Serial frame check register, seeded with ones, fed MSB first.
    // Running a message followed by eight zeros yields its check byte;
    // running a message with its check byte yields zero when intact.
    function automatic sbc_byte_t sbc_crc_run(input sbc_frame_t bits);
        sbc_byte_t sr;
        logic fb;
        sr = `SBC_CRC_SEED;
        for (int i = 31; i >= 0; i--) begin
            fb = sr[7];
            sr = {sr[6:0], bits[i]};
            if (fb) begin
                sr = sr ^ `SBC_CRC_POLY;
            end
        end
        return sr;
    endfunction
endpackage

//--- verilog/sbc_link_if.sv
// Interface joining the bus master end and the sensor end.
`timescale 1ns/100ps
interface sbc_link_if (
    input wire logic clk
);
    logic cmdValid;
    logic [31:0] cmdFrame;
    logic rspValid;
    logic [31:0] rspFrame;

    modport dev (
        input clk,
        input cmdValid,
        input cmdFrame,
        output rspValid,
        output rspFrame
    );

    modport mst (
        input clk,
        output cmdValid,
        output cmdFrame,
        input rspValid,
        input rspFrame
    );
endinterface

//--- verilog/sbc_master.sv
// Bus master end: builds command frames and checks read responses.
`timescale 1ns/100ps
`include "sbc_consts.svh"
module sbc_master #(
    parameter int RSP_TIMEOUT = `SBC_RSP_TIMEOUT
) (
    input wire logic clk,
    input wire logic reset,
    sbc_link_if.mst link,
    input wire logic reqValid,
    input wire sbc_pkg::sbc_nibble_t reqNode,
    input wire sbc_pkg::sbc_nibble_t reqCmd,
    input wire logic [15:0] reqData,
    output logic busy,
    output logic doneValid,
    output logic doneOk,
    output logic doneTimeout,
    output logic [15:0] doneData
);
    import sbc_pkg::*;

    sbc_mst_state_e state_ff, nxt_state;
    logic cmdValid_ff, nxt_cmdValid;
    sbc_frame_t cmdFrame_ff, nxt_cmdFrame;
    sbc_frame_t rsp_ff, nxt_rsp;
    sbc_nibble_t node_ff, nxt_node;
    logic [15:0] timer_ff, nxt_timer;
    logic busy_ff, nxt_busy;
    logic doneValid_ff, nxt_doneValid;
    logic doneOk_ff, nxt_doneOk;
    logic doneTimeout_ff, nxt_doneTimeout;
    logic [15:0] doneData_ff, nxt_doneData;
    logic [23:0] msg;
    logic [15:0] sendData;
    logic isRead;

    // ----------------------------------------------------------------
    // Frame build
    // ----------------------------------------------------------------
    // A read carries only the even byte address; the low nine bits go out as zero.
    always_comb begin
        isRead = (reqCmd == `SBC_CMD_READ); // RULE1
        sendData = isRead ? {reqData[15:9], `SBC_READ_PAD} : reqData; // RULE7
        msg = {reqNode, reqCmd, sendData}; // RULE2 RULE3
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Only reads wait for an answer; other commands finish after sending.
    always_comb begin
        nxt_state = state_ff;
        nxt_cmdValid = 1'b0;
        nxt_cmdFrame = cmdFrame_ff;
        nxt_rsp = rsp_ff;
        nxt_node = node_ff;
        nxt_timer = timer_ff;
        nxt_busy = busy_ff;
        nxt_doneValid = 1'b0;
        nxt_doneOk = doneOk_ff;
        nxt_doneTimeout = 1'b0;
        nxt_doneData = doneData_ff;
        unique case (state_ff)
            SBC_MST_IDLE: begin
                if (reqValid) begin
                    nxt_cmdValid = 1'b1;
                    nxt_cmdFrame = {msg, sbc_crc_run({msg, `SBC_CRC_ZERO})}; // RULE13 RULE14
                    nxt_node = reqNode;
                    nxt_timer = 16'(RSP_TIMEOUT);
                    if (isRead) begin
                        nxt_state = SBC_MST_WAIT;
                        nxt_busy = 1'b1;
                    end else begin
                        nxt_doneValid = 1'b1;
                        nxt_doneOk = 1'b1;
                    end
                end
            end
            SBC_MST_WAIT: begin
                if (link.rspValid) begin
                    nxt_rsp = link.rspFrame;
                    nxt_state = SBC_MST_CHECK;
                end else if (timer_ff == 16'h0000) begin
                    // Reserved codes and unmatched nodes never answer.
                    nxt_state = SBC_MST_IDLE;
                    nxt_busy = 1'b0;
                    nxt_doneValid = 1'b1;
                    nxt_doneOk = 1'b0;
                    nxt_doneTimeout = 1'b1;
                end else begin
                    nxt_timer = timer_ff - 16'h0001;
                end
            end
            SBC_MST_CHECK: begin
                nxt_state = SBC_MST_IDLE;
                nxt_busy = 1'b0;
                nxt_doneValid = 1'b1;
                nxt_doneData = rsp_ff[`SBC_DATA_HI:`SBC_DATA_LO];
                nxt_doneOk = (sbc_crc_run(rsp_ff) == `SBC_CRC_ZERO) && // RULE13 RULE14
                    (rsp_ff[`SBC_ADDR_HI:`SBC_ADDR_LO] == node_ff) &&
                    (rsp_ff[`SBC_CMD_HI:`SBC_CMD_LO] == `SBC_CMD_READ);
            end
            default: begin
                nxt_state = SBC_MST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= SBC_MST_IDLE;
            cmdValid_ff <= 1'b0;
            cmdFrame_ff <= `SBC_FRAME_ZERO;
            rsp_ff <= `SBC_FRAME_ZERO;
            node_ff <= `SBC_GLOBAL_ADDR;
            timer_ff <= 16'h0000;
            busy_ff <= 1'b0;
            doneValid_ff <= 1'b0;
            doneOk_ff <= 1'b0;
            doneTimeout_ff <= 1'b0;
            doneData_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cmdValid_ff <= nxt_cmdValid;
            cmdFrame_ff <= nxt_cmdFrame;
            rsp_ff <= nxt_rsp;
            node_ff <= nxt_node;
            timer_ff <= nxt_timer;
            busy_ff <= nxt_busy;
            doneValid_ff <= nxt_doneValid;
            doneOk_ff <= nxt_doneOk;
            doneTimeout_ff <= nxt_doneTimeout;
            doneData_ff <= nxt_doneData;
        end
    end

    assign link.cmdValid = cmdValid_ff;
    assign link.cmdFrame = cmdFrame_ff;
    assign busy = busy_ff;
    assign doneValid = doneValid_ff;
    assign doneOk = doneOk_ff;
    assign doneTimeout = doneTimeout_ff;
    assign doneData = doneData_ff;
endmodule

//--- verification/sbc_tb_pkg.sv
// Frame check helpers shared by the bench and the link checker.
package sbc_tb_pkg;
    // Ones seed, polynomial 0x2f, frame bits shifted in MSB first.
    function automatic logic [7:0] sbc_chk(input logic [31:0] f);
        logic [7:0] r;
        r = 8'hff;
        for (int i = 31; i >= 0; i--) begin
            r = {r[6:0], f[i]} ^ (r[7] ? 8'h2f : 8'h00);
        end
        return r;
    endfunction

    // Appends the check byte, worked out over the message and eight zeros.
    function automatic logic [31:0] sbc_mk(input logic [23:0] m);
        return {m, sbc_chk({m, 8'h00})};
    endfunction
endpackage

//--- verification/sbc_link_checker.sv
// Concurrent checks on the link that joins the master end and the sensor end.
`timescale 1ns/100ps
module sbc_link_checker
    import sbc_tb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire logic [31:0] cmdFrame,
    input wire logic rspValid,
    input wire logic [31:0] rspFrame
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Answers come two edges after a read, echo the node and code, carry a good check.
    rsp_delay_a: assert property (rspValid |-> $past(cmdValid, 2))
        else $error("answer without a command two cycles before");
    rsp_read_only_a: assert property (rspValid |-> $past(cmdFrame[27:24], 2) == 4'h0)
        else $error("answer to a command other than a read");
    rsp_node_a: assert property (rspValid |-> rspFrame[31:28] == $past(cmdFrame[31:28], 2))
        else $error("answer node differs from the read node");
    rsp_echo_a: assert property (rspValid |-> rspFrame[27:24] == 4'h0)
        else $error("answer code is not the read code");
    rsp_check_a: assert property (rspValid |-> sbc_chk(rspFrame) == 8'h00)
        else $error("answer check byte is wrong");
    // Broadcast reads stay silent; the bench never gives the device on this link node zero.
    global_silent_a: assert property (cmdValid && cmdFrame[31:28] == 4'h0 |-> ##2 !rspValid)
        else $error("broadcast read was answered");
    // The master end builds well formed commands.
    cmd_check_a: assert property (cmdValid |-> sbc_chk(cmdFrame) == 8'h00)
        else $error("command check byte is wrong");
    read_pad_a: assert property (cmdValid && cmdFrame[27:24] == 4'h0 |-> cmdFrame[16:8] == 9'h000)
        else $error("read command low data bits not zero");

    // Main traffic kinds seen on the link.
    cover property (rspValid);
    cover property (cmdValid && cmdFrame[27:24] == 4'h8);
    cover property (cmdValid && cmdFrame[27:24] == 4'hb);
endmodule

//--- verification/sensor_bus_cmd_response_test.sv
// Bench joining both ends, plus a second sensor end driven by hand.
`timescale 1ns/100ps
module sensor_bus_cmd_response_test;
    import sbc_tb_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reqValid = 1'b0;
    logic [3:0] reqNode = 4'h0, reqCmd = 4'h0;
    logic [15:0] reqData = 16'h0000, doneData;
    logic busy, doneValid, doneOk, doneTimeout, wrV, colA, ignB, crcB;
    logic wrEn = 1'b0;
    logic [3:0] nodeB = 4'h5;
    logic [7:0] wrAddr = 8'h00, wrData = 8'h00, wrA, wrD;
    int fail_count = 0, tests_run = 0, cycles = 0;

    sbc_link_if linkA (.clk(clk));
    sbc_link_if linkB (.clk(clk));
    initial linkB.cmdValid = 1'b0;
    initial linkB.cmdFrame = 32'h0000_0000;

    sbc_master #(.RSP_TIMEOUT(8)) i_sbc_master (.clk(clk), .reset(reset), .link(linkA),
        .reqValid(reqValid), .reqNode(reqNode), .reqCmd(reqCmd), .reqData(reqData),
        .busy(busy), .doneValid(doneValid), .doneOk(doneOk), .doneTimeout(doneTimeout),
        .doneData(doneData));
    // Bytes 0x20 and 0x21 are made unreadable on this end.
    sbc_device #(.READ_MASK(~(256'h3 << 32))) i_sbc_device (.clk(clk), .reset(reset),
        .link(linkA), .nodeAddress(4'h5), .localWrEn(wrEn), .localWrAddr(wrAddr),
        .localWrData(wrData), .writeReqValid(wrV), .writeReqAddr(wrA), .writeReqData(wrD),
        .collectModeReq(colA), .crcError(), .cmdIgnored());
    sbc_device i_sbc_device_b (.clk(clk), .reset(reset), .link(linkB), .nodeAddress(nodeB),
        .localWrEn(wrEn), .localWrAddr(wrAddr), .localWrData(wrData), .writeReqValid(),
        .writeReqAddr(), .writeReqData(), .collectModeReq(), .crcError(crcB),
        .cmdIgnored(ignB));
    sbc_link_checker i_sbc_link_checker (.clk(clk), .reset(reset),
        .cmdValid(linkA.cmdValid), .cmdFrame(linkA.cmdFrame), .rspValid(linkA.rspValid),
        .rspFrame(linkA.rspFrame));

    // Clock and hang guard; the ceiling is well above the expected run.
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Local byte write, shared by both sensor ends.
    task automatic lwr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wrEn = 1'b1;
        wrAddr = a;
        wrData = d;
        @(negedge clk);
        wrEn = 1'b0;
    endtask

    // Master request; returns once done is seen, bounded so a lost answer cannot hang.
    task automatic mreq(input logic [3:0] n, input logic [3:0] c, input logic [15:0] d);
        int k;
        k = 0;
        @(negedge clk);
        reqValid = 1'b1;
        reqNode = n;
        reqCmd = c;
        reqData = d;
        @(negedge clk);
        reqValid = 1'b0;
        chk(busy, c == 4'h0);
        while (doneValid !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic rd(input logic [15:0] d, input logic [15:0] exp);
        mreq(4'h5, 4'h0, d);
        chk({busy, doneOk, doneTimeout, doneData}, {1'b0, 1'b1, 1'b0, exp});
    endtask

    // Hand driven command on the second link; ends in the cycle the answer is due.
    // The frame lines are inverted once released, so stale data cannot pass as held.
    task automatic bsend(input logic [31:0] f, input logic poke);
        @(negedge clk);
        linkB.cmdValid = 1'b1;
        linkB.cmdFrame = f;
        @(negedge clk);
        linkB.cmdValid = 1'b0;
        linkB.cmdFrame = ~f;
        wrEn = poke;
        wrAddr = 8'h10;
        wrData = 8'hee;
        @(negedge clk);
        wrEn = 1'b0;
    endtask

    task automatic t_read_map();
        lwr(8'h10, 8'h3c);
        lwr(8'h11, 8'ha5);
        lwr(8'h20, 8'h77);
        lwr(8'h21, 8'h66);
        rd(16'h1000, 16'ha53c);
        rd(16'h1100, 16'ha53c);
        rd(16'h2000, 16'h0000);
        rd(16'h8000, 16'h0000);
    endtask

    task automatic t_node();
        mreq(4'h3, 4'h0, 16'h1000);
        chk({doneTimeout, doneOk}, 2'b10);
        mreq(4'h0, 4'h0, 16'h1000);
        chk({doneTimeout, doneOk}, 2'b10);
    endtask

    task automatic t_write_periodic_collection_mode();
        mreq(4'h5, 4'h8, 16'h2a5b);
        chk(doneOk, 1'b1);
        repeat (2) @(negedge clk);
        chk({wrV, wrA, wrD}, {1'b1, 8'h2a, 8'h5b});
        mreq(4'h5, 4'hb, 16'hffff);
        repeat (2) @(negedge clk);
        chk(colA, 1'b1);
    endtask

    task automatic t_reserved();
        for (int c = 1; c < 16; c++) begin
            if (c != 8 && c != 11) begin
                bsend(sbc_mk({4'h5, c[3:0], 16'h1234}), 1'b0);
                chk({linkB.rspValid, ignB}, 2'b01);
            end
        end
    endtask

    // Byte 0x10 changes during decode; the answer keeps the old value.
    task automatic t_snapshot();
        bsend(sbc_mk({4'h5, 4'h0, 16'h1000}), 1'b1);
        chk(linkB.rspValid, 1'b1);
        chk(linkB.rspFrame, sbc_mk({4'h5, 4'h0, 16'ha53c}));
        bsend(sbc_mk({4'h5, 4'h0, 16'h1000}), 1'b0);
        chk(linkB.rspFrame, sbc_mk({4'h5, 4'h0, 16'ha5ee}));
        bsend(sbc_mk({4'h5, 4'h0, 16'h1000}) ^ 32'h1, 1'b0);
        chk({linkB.rspValid, crcB}, 2'b01);
        // A sensor set to node zero must still ignore a broadcast read.
        nodeB = 4'h0;
        bsend(sbc_mk({4'h0, 4'h0, 16'h1000}), 1'b0);
        chk({linkB.rspValid, ignB}, 2'b01);
        nodeB = 4'h5;
    endtask

    // Main sequence.
    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        t_read_map();
        t_node();
        t_write_periodic_collection_mode();
        t_reserved();
        t_snapshot();
        complete_run();
    end
endmodule
